// >>> logic/devcap_defs.svh
// Offsets, field positions, reset values and bus codes of the register bank
// Assumes inclusion by the package, the register modules, the checker and the bench
`ifndef DEVCAP_DEFS_SVH
`define DEVCAP_DEFS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_DEV_CAP       8'hc4
`define ADDR_DEV_CTRL      8'hc8

// ****************************************
// Field positions
// ****************************************
`define CAP_MPS_LSB        0
`define CAP_PHANTOM_LSB    3
`define CAP_EXT_TAG_BIT    5
`define CAP_L0S_LAT_LSB    6
`define CAP_L1_LAT_LSB     9
`define CAP_ROLE_ERR_BIT   15
`define CAP_SPL_VAL_LSB    18
`define CAP_SPL_SCL_LSB    26
`define CTL_ERR_EN_LSB     0
`define CTL_RELAX_BIT      4
`define CTL_MPS_LSB        5
`define CTL_EXT_TAG_BIT    8
`define CTL_PHANTOM_BIT    9
`define CTL_AUX_PWR_BIT    10
`define CTL_NO_SNOOP_BIT   11
`define CTL_MRRS_LSB       12

// ****************************************
// Reset and fixed values
// ****************************************
`define MPS_CAP_STRAP_LO   3'h1
`define MPS_CAP_STRAP_HI   3'h2
`define ROLE_ERR_RST       1'b1
`define L0S_LAT_VAL        3'h0
`define L1_LAT_VAL         3'h0
`define SPL_VAL_RST        8'h00
`define SPL_SCL_RST        2'h0
`define ERR_EN_RST         4'h0
`define MPS_RST            3'h0
`define AUX_PWR_RST        1'b0

// ****************************************
// AXI responses
// ****************************************
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// >>> logic/devcap_pkg.sv
// Types shared by the register bank modules
// Assumes devcap_defs.svh is on the include path
`include "devcap_defs.svh"

package devcap_pkg;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CAP  = 2'b01,
    SEL_CTRL = 2'b10
  } reg_sel_t;

  typedef struct packed {
    logic [2:0] mps_cap;
    logic       loaded;
    logic       role_err;
    logic [7:0] spl_value;
    logic [1:0] spl_scale;
    logic [3:0] err_en;
    logic [2:0] mps;
    logic       aux_pwr;
  } regs_state_t;

  typedef struct packed {
    logic        aw_held;
    logic        w_held;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        wr_go;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic [7:0]  araddr;
    logic        rd_go;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_state_t;

endpackage : devcap_pkg

// >>> logic/cfg_bus_if.sv
// Internal register access path between bus slave and register bank
// Assumes one clock domain; hit and read data are combinational answers
interface cfg_bus_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_hit;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_hit;

  modport bus (
    output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
    input  wr_hit, rd_data, rd_hit
  );

  modport regs (
    input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
    output wr_hit, rd_data, rd_hit
  );
endinterface : cfg_bus_if

// >>> logic/pin_sync.sv
// Three stage pin synchroniser with agreement filter
// Assumes an asynchronous level input and the core clock
module pin_sync
  import devcap_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);

  sync_state_t s;
  sync_state_t next_s;

  always_comb
  begin
    next_s    = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3)
    begin
      next_s.q = s.s3;
    end
    if (!aresetn)
    begin
      next_s = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    s <= next_s;
  end

  assign level = s.q;

endmodule : pin_sync

// >>> logic/axil_slave.sv
// AXI4-Lite slave front end, one write and one read in flight
// Assumes the register bank answers hit and read data combinationally
`include "devcap_defs.svh"
module axil_slave
  import devcap_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  cfg_bus_if.bus           cfg
);

  axil_state_t s;
  axil_state_t next_s;

  always_comb
  begin
    next_s = s;
    if (awvalid && s.awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_held = 1'b1;
      next_s.wdata  = wdata;
      next_s.wstrb  = wstrb;
    end
    if (s.aw_held && s.w_held && !s.wr_go && !s.bvalid)
    begin
      next_s.wr_go   = 1'b1;
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
    end
    if (s.wr_go)
    begin
      next_s.wr_go  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = cfg.wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_held && !next_s.wr_go && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.wr_go && !next_s.bvalid;
    if (arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.araddr  = araddr;
      next_s.rd_go   = 1'b1;
    end
    if (s.rd_go)
    begin
      next_s.rd_go  = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata  = cfg.rd_data;
      next_s.rresp  = cfg.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s.rvalid && rready)
    begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
    if (!aresetn)
    begin
      next_s         = '0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
      next_s.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    s <= next_s;
  end

  assign awready     = s.awready;
  assign wready      = s.wready;
  assign bvalid      = s.bvalid;
  assign bresp       = s.bresp;
  assign arready     = s.arready;
  assign rvalid      = s.rvalid;
  assign rdata       = s.rdata;
  assign rresp       = s.rresp;
  assign cfg.wr_en   = s.wr_go;
  assign cfg.wr_addr = s.awaddr;
  assign cfg.wr_data = s.wdata;
  assign cfg.wr_strb = s.wstrb;
  assign cfg.rd_addr = s.araddr;

endmodule : axil_slave

// >>> logic/pcie_device_cap_ctrl_regs.sv
// Device capability and device control words of one switch port
// Assumes AXI4-Lite configuration access, straps on pins, and a
// power-on reset for the sticky bit from logic on the same clock
//
// Notes on behaviour
// RULE_01 - Payload capability resets to 001 or 010 by strap; autoload replaces it.
// RULE_02 - Phantom function capability bits 4:3 always read 00.
// RULE_03 - Extended tag capability bit 5 always reads zero.
// RULE_04 - Standby exit latency bits 8:6 read-only, reset 000.
// RULE_05 - Sleep exit latency bits 11:9 read-only, writes ignored.
// RULE_06 - Role-based error capability bit 15 resets to 1; autoload may change.
// RULE_07 - Upstream port loads slot power value 25:18 from message; else 00h.
// RULE_08 - Upstream port loads slot power scale 27:26 from message; reset 00.
// RULE_09 - Four error reporting enables, bits 0 to 3, read-write, reset 0.
// RULE_10 - Relaxed ordering enable bit 4 always reads zero.
// RULE_11 - Payload size 7:5 read-write, reset 000, over-range writes clamp to capability.
// RULE_12 - Extended tag enable bit 8 and phantom enable bit 9 read zero.
// RULE_13 - Auxiliary power enable bit 10 sticky read-write, reset 0.
// RULE_14 - No snoop enable bit 11 always reads zero.
// RULE_15 - Read request size 14:12 hardwired to 000.
// RULE_16 - Reserved bits read zero and ignore writes.
`include "devcap_defs.svh"
module pcie_device_cap_ctrl_regs
  import devcap_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        aux_por_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        payload_size_strap,
  input  wire logic        port_is_upstream,
  input  wire logic        slot_power_msg_valid,
  input  wire logic [7:0]  slot_power_msg_value,
  input  wire logic [1:0]  slot_power_msg_scale,
  input  wire logic        autoload_valid,
  input  wire logic [2:0]  autoload_payload_cap,
  input  wire logic        autoload_role_err,
  output logic [2:0]       payload_size_cap,
  output logic [2:0]       max_payload_size,
  output logic [3:0]       error_report_en,
  output logic             aux_power_en,
  output logic [7:0]       slot_power_value,
  output logic [1:0]       slot_power_scale
);

  // ****************************************
  // Strap synchronisers
  // ****************************************
  logic [1:0] strap_pins;
  logic [1:0] strap_levels;
  logic       strap_payload;
  logic       strap_upstream;

  assign strap_pins = {port_is_upstream, payload_size_strap};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_strap
      pin_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (strap_pins[g]),
        .level   (strap_levels[g])
      );
    end
  endgenerate

  assign strap_payload  = strap_levels[0];
  assign strap_upstream = strap_levels[1];

  // ****************************************
  // Bus slave
  // ****************************************
  cfg_bus_if cfg ();

  axil_slave u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .cfg     (cfg)
  );

  // ****************************************
  // Decode and read words
  // ****************************************
  function automatic reg_sel_t reg_select(input logic [7:0] addr);
    reg_sel_t sel;
    case (addr)
      `ADDR_DEV_CAP:  sel = SEL_CAP;
      `ADDR_DEV_CTRL: sel = SEL_CTRL;
      default:        sel = SEL_NONE;
    endcase
    return sel;
  endfunction : reg_select

  function automatic logic [31:0] cap_word(input regs_state_t r);
    logic [31:0] w;
    w = 32'h0000_0000; // RULE_16
    w[`CAP_MPS_LSB +: 3]      = r.mps_cap; // RULE_01
    w[`CAP_PHANTOM_LSB +: 2]  = 2'h0; // RULE_02
    w[`CAP_EXT_TAG_BIT]       = 1'b0; // RULE_03
    w[`CAP_L0S_LAT_LSB +: 3]  = `L0S_LAT_VAL; // RULE_04
    w[`CAP_L1_LAT_LSB +: 3]   = `L1_LAT_VAL; // RULE_05
    w[`CAP_ROLE_ERR_BIT]      = r.role_err; // RULE_06
    w[`CAP_SPL_VAL_LSB +: 8]  = r.spl_value; // RULE_07
    w[`CAP_SPL_SCL_LSB +: 2]  = r.spl_scale; // RULE_08
    return w;
  endfunction : cap_word

  function automatic logic [31:0] ctrl_word(input regs_state_t r);
    logic [31:0] w;
    w = 32'h0000_0000; // RULE_16
    w[`CTL_ERR_EN_LSB +: 4] = r.err_en; // RULE_09
    w[`CTL_RELAX_BIT]       = 1'b0; // RULE_10
    w[`CTL_MPS_LSB +: 3]    = r.mps; // RULE_11
    w[`CTL_EXT_TAG_BIT]     = 1'b0; // RULE_12
    w[`CTL_PHANTOM_BIT]     = 1'b0; // RULE_12
    w[`CTL_AUX_PWR_BIT]     = r.aux_pwr; // RULE_13
    w[`CTL_NO_SNOOP_BIT]    = 1'b0; // RULE_14
    w[`CTL_MRRS_LSB +: 3]   = 3'h0; // RULE_15
    return w;
  endfunction : ctrl_word

  // ****************************************
  // Register state
  // ****************************************
  regs_state_t s;
  regs_state_t next_s;
  reg_sel_t    rd_sel;
  reg_sel_t    wr_sel;
  logic [2:0]  strap_cap;
  logic [2:0]  wr_mps;

  assign rd_sel = reg_select(cfg.rd_addr);
  assign wr_sel = reg_select(cfg.wr_addr);

  always_comb
  begin
    case (rd_sel)
      SEL_CAP:  cfg.rd_data = cap_word(s);
      SEL_CTRL: cfg.rd_data = ctrl_word(s);
      default:  cfg.rd_data = 32'h0000_0000;
    endcase
  end

  assign cfg.rd_hit = (rd_sel != SEL_NONE);
  assign cfg.wr_hit = (wr_sel != SEL_NONE);

  assign strap_cap = strap_payload ? `MPS_CAP_STRAP_HI
                                   : `MPS_CAP_STRAP_LO;
  assign wr_mps    = cfg.wr_data[`CTL_MPS_LSB +: 3];

  always_comb
  begin
    next_s = s;
    if (autoload_valid)
    begin
      next_s.mps_cap  = autoload_payload_cap; // RULE_01
      next_s.role_err = autoload_role_err; // RULE_06
      next_s.loaded   = 1'b1;
    end
    else if (!s.loaded)
    begin
      next_s.mps_cap = strap_cap; // RULE_01
    end
    if (strap_upstream && slot_power_msg_valid)
    begin
      next_s.spl_value = slot_power_msg_value; // RULE_07
      next_s.spl_scale = slot_power_msg_scale; // RULE_08
    end
    if (cfg.wr_en && wr_sel == SEL_CTRL)
    begin
      if (cfg.wr_strb[0])
      begin
        next_s.err_en = cfg.wr_data[`CTL_ERR_EN_LSB +: 4]; // RULE_09
        if (wr_mps > s.mps_cap)
        begin
          next_s.mps = s.mps_cap; // RULE_11
        end
        else
        begin
          next_s.mps = wr_mps; // RULE_11
        end
      end
      if (cfg.wr_strb[1])
      begin
        next_s.aux_pwr = cfg.wr_data[`CTL_AUX_PWR_BIT]; // RULE_13
      end
    end
    if (!aresetn)
    begin
      next_s.mps_cap   = strap_cap; // RULE_01
      next_s.loaded    = 1'b0;
      next_s.role_err  = `ROLE_ERR_RST; // RULE_06
      next_s.spl_value = `SPL_VAL_RST; // RULE_07
      next_s.spl_scale = `SPL_SCL_RST; // RULE_08
      next_s.err_en    = `ERR_EN_RST; // RULE_09
      next_s.mps       = `MPS_RST; // RULE_11
    end
    if (!aux_por_n)
    begin
      next_s.aux_pwr = `AUX_PWR_RST; // RULE_13
    end
  end

  always_ff @(posedge aclk)
  begin
    s <= next_s;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign payload_size_cap = s.mps_cap;
  assign max_payload_size = s.mps;
  assign error_report_en  = s.err_en;
  assign aux_power_en     = s.aux_pwr;
  assign slot_power_value = s.spl_value;
  assign slot_power_scale = s.spl_scale;

endmodule : pcie_device_cap_ctrl_regs

// >>> test/devcap_checker.sv
// Concurrent checks on the ports of the register bank
// Assumes a bind to the top module and one clock domain
`include "devcap_defs.svh"
module devcap_checker (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       aux_por_n,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       port_is_upstream,
  input wire logic       slot_power_msg_valid,
  input wire logic [7:0] slot_power_msg_value,
  input wire logic [1:0] slot_power_msg_scale,
  input wire logic [2:0] payload_size_cap,
  input wire logic [2:0] max_payload_size,
  input wire logic [3:0] error_report_en,
  input wire logic       aux_power_en,
  input wire logic [7:0] slot_power_value,
  input wire logic [1:0] slot_power_scale
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****************************************
  // Sequences and assertions
  // ****************************************
  sequence up_msg_s;
    port_is_upstream [*8] ##0 slot_power_msg_valid;
  endsequence
  sequence wr_take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_ERR_RESET: assert property ($rose(aresetn) |->
    error_report_en == `ERR_EN_RST && max_payload_size == `MPS_RST)
    else $error("control fields not at reset value");
  AST_MPS_CLAMP: assert property ($changed(max_payload_size) |->
    max_payload_size <= payload_size_cap)
    else $error("payload size above capability");
  AST_SPL_HOLD: assert property (!slot_power_msg_valid |=>
    $stable(slot_power_value) && $stable(slot_power_scale))
    else $error("slot power changed without message");
  AST_SPL_LOAD: assert property (up_msg_s |=>
    slot_power_value == $past(slot_power_msg_value) &&
    slot_power_scale == $past(slot_power_msg_scale))
    else $error("slot power message not captured");
  AST_AUX_STICKY: assert property (@(posedge aclk)
    disable iff (!aux_por_n)
    $changed(aux_power_en) && $past(aux_por_n) |-> $rose(s_axi_bvalid))
    else $error("aux enable changed outside a write");
  AST_B_TIMING: assert property (wr_take_s |-> ##3 s_axi_bvalid)
    else $error("write response late");
  AST_R_TIMING: assert property (s_axi_arvalid && s_axi_arready |->
    ##2 s_axi_rvalid)
    else $error("read data late");
  AST_AR_BLOCK: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_arready [*2])
    else $error("second read accepted in flight");
endmodule : devcap_checker

// >>> test/tb_top.sv
// Self-checking bench for the capability and control words
// Assumes design and checker files compiled before this one
`include "devcap_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, aux_por_n, strap, up, msg_vld, al_vld;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, al_role;
  logic        arvalid, arready, rvalid, rready, aux;
  logic [7:0]  awaddr, araddr, msg_val, spl_val;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, err_en;
  logic [2:0]  cap, mps, al_cap;
  logic [1:0]  bresp, rresp, msg_scl, spl_scl, rs;
  int          num_errors, n_checks;

  pcie_device_cap_ctrl_regs u_dut (
    .aclk(aclk), .aresetn(aresetn), .aux_por_n(aux_por_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .payload_size_strap(strap),
    .port_is_upstream(up), .slot_power_msg_valid(msg_vld),
    .slot_power_msg_value(msg_val), .slot_power_msg_scale(msg_scl),
    .autoload_valid(al_vld), .autoload_payload_cap(al_cap),
    .autoload_role_err(al_role), .payload_size_cap(cap),
    .max_payload_size(mps), .error_report_en(err_en),
    .aux_power_en(aux), .slot_power_value(spl_val),
    .slot_power_scale(spl_scl));

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: resp %h, want %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    chk_resp(bvalid ? bresp : 2'bxx, er);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rvalid ? rdata : 32'hxxxx_xxxx;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic pulse_msg(input logic [7:0] v, input logic [1:0] s);
    @(posedge aclk);
    msg_vld <= 1'b1;
    msg_val <= v;
    msg_scl <= s;
    @(posedge aclk);
    msg_vld <= 1'b0;
  endtask : pulse_msg

  function automatic logic [31:0] exp_cap(input logic [2:0] c,
    input logic r, input logic [7:0] v, input logic [1:0] s);
    return {4'h0, s, v, 2'h0, r, 3'h0, `L1_LAT_VAL, `L0S_LAT_VAL,
            1'b0, 2'h0, c};
  endfunction : exp_cap

  task automatic check_reg(input logic [7:0] a, input logic [31:0] e);
    axi_read(a, rd, rs);
    chk_resp(rs, `RESP_OKAY);
    chk_word(rd, e);
  endtask : check_reg

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {aresetn, aux_por_n, msg_vld, al_vld, al_role, awvalid} = '0;
    {wvalid, bready, arvalid, rready, msg_val, msg_scl, al_cap} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    strap = 1'b1;
    up = 1'b1;
    num_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    aux_por_n <= 1'b1;
    repeat (4) @(posedge aclk);
    check_reg(`ADDR_DEV_CAP, exp_cap(3'h2, 1'b1, 8'h00, 2'h0));
    check_reg(`ADDR_DEV_CTRL, 32'h0000_0000);
    axi_write(`ADDR_DEV_CAP, 32'hffff_ffff, `RESP_OKAY);
    check_reg(`ADDR_DEV_CAP, exp_cap(3'h2, 1'b1, 8'h00, 2'h0));
    axi_write(`ADDR_DEV_CTRL, 32'hffff_ffff, `RESP_OKAY);
    check_reg(`ADDR_DEV_CTRL, 32'h0000_044f);
    chk_word({25'h0, mps, err_en}, 32'h0000_002f);
    for (int v = 0; v < 8; v++)
    begin
      axi_write(`ADDR_DEV_CTRL, 32'h0000_0400 | (v << 5), `RESP_OKAY);
      check_reg(`ADDR_DEV_CTRL, 32'h0000_0400 | ((v > 2 ? 2 : v) << 5));
    end
    axi_write(8'hd0, 32'hffff_ffff, `RESP_SLVERR);
    axi_read(8'hd0, rd, rs);
    chk_resp(rs, `RESP_SLVERR);
    chk_word(rd, 32'h0000_0000);
    pulse_msg(8'ha5, 2'h3);
    check_reg(`ADDR_DEV_CAP, exp_cap(3'h2, 1'b1, 8'ha5, 2'h3));
    up <= 1'b0;
    repeat (8) @(posedge aclk);
    pulse_msg(8'h5a, 2'h1);
    check_reg(`ADDR_DEV_CAP, exp_cap(3'h2, 1'b1, 8'ha5, 2'h3));
    @(posedge aclk);
    al_vld <= 1'b1;
    @(posedge aclk);
    al_vld <= 1'b0;
    check_reg(`ADDR_DEV_CAP, exp_cap(3'h0, 1'b0, 8'ha5, 2'h3));
    chk_word({18'h0, aux, cap, spl_scl, spl_val}, 32'h0000_23a5);
    strap <= 1'b0;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    check_reg(`ADDR_DEV_CTRL, 32'h0000_0400);
    check_reg(`ADDR_DEV_CAP, exp_cap(3'h1, 1'b1, 8'h00, 2'h0));
    @(posedge aclk);
    aux_por_n <= 1'b0;
    @(posedge aclk);
    aux_por_n <= 1'b1;
    check_reg(`ADDR_DEV_CTRL, 32'h0000_0000);
    wstrb <= 4'h2;
    axi_write(`ADDR_DEV_CTRL, 32'hffff_ffff, `RESP_OKAY);
    check_reg(`ADDR_DEV_CTRL, 32'h0000_0400);
    complete_run;
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    complete_run;
  end
endmodule : tb_top

bind pcie_device_cap_ctrl_regs devcap_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .aux_por_n(aux_por_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .port_is_upstream(port_is_upstream),
  .slot_power_msg_valid(slot_power_msg_valid),
  .slot_power_msg_value(slot_power_msg_value),
  .slot_power_msg_scale(slot_power_msg_scale),
  .payload_size_cap(payload_size_cap),
  .max_payload_size(max_payload_size),
  .error_report_en(error_report_en), .aux_power_en(aux_power_en),
  .slot_power_value(slot_power_value),
  .slot_power_scale(slot_power_scale));
